// *** rtl/dacfmt_top.v ***
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "dacfmt_defines.vh"

module dacfmt_top (
    // clock and reset
    input wire I_CLK,
    input wire I_SYS_RST,
    // axi4-lite write address
    input wire [3:0] I_AWADDR,
    input wire I_AWVALID,
    output wire O_AWREADY,
    // axi4-lite write data
    input wire [31:0] I_WDATA,
    input wire [3:0] I_WSTRB,
    input wire I_WVALID,
    output wire O_WREADY,
    // axi4-lite write response
    output wire [1:0] O_BRESP,
    output wire O_BVALID,
    input wire I_BREADY,
    // axi4-lite read address
    input wire [3:0] I_ARADDR,
    input wire I_ARVALID,
    output wire O_ARREADY,
    // axi4-lite read data
    output wire [31:0] O_RDATA,
    output wire [1:0] O_RRESP,
    output wire O_RVALID,
    input wire I_RREADY,
    // converter core side
    output wire [11:0] O_CORE_CODE,
    output wire O_CORE_EIGHT_BIT,
    output wire O_CORE_GAIN,
    output wire O_CORE_ENABLE
);

    // write channel holding registers
    reg aw_hold_ff;
    reg [3:0] awaddr_ff;
    reg w_hold_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;

    // read channel
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;

    // block state
    reg [15:0] data_ff;
    reg res_ff;
    reg fmt_ff;
    reg just_ff;
    reg gain_ff;
    reg enable_ff;
    reg [11:0] code_ff;

    wire [15:0] field_mask;
    wire [15:0] read_word;
    wire [11:0] core_code;
    wire do_write;
    wire [15:0] lane_mask;
    wire [15:0] wr_mask;
    wire [15:0] nxt_data;
    wire [31:0] ctrl_word;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;

    dacfmt_layout i_dacfmt_layout (
        .i_res(res_ff),
        .i_fmt(fmt_ff),
        .i_just(just_ff),
        .i_word(data_ff),
        .o_field_mask(field_mask),
        .o_read_word(read_word),
        .o_core_code(core_code)
    );

    assign O_AWREADY = !aw_hold_ff && !bvalid_ff;
    assign O_WREADY = !w_hold_ff && !bvalid_ff;
    assign O_BVALID = bvalid_ff;
    assign O_BRESP = bresp_ff;
    assign O_ARREADY = !rvalid_ff;
    assign O_RVALID = rvalid_ff;
    assign O_RDATA = rdata_ff;
    assign O_RRESP = rresp_ff;

    assign O_CORE_CODE = code_ff;
    assign O_CORE_EIGHT_BIT = res_ff;
    assign O_CORE_GAIN = gain_ff;
    assign O_CORE_ENABLE = enable_ff;

    // a write commits once both address and data are held
    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

    // only lanes with strobes and only bits of the active field take data
    assign lane_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wr_mask = lane_mask & field_mask; // RULE10
    assign nxt_data = (data_ff & ~wr_mask) | (wdata_ff[15:0] & wr_mask);

    assign ctrl_word = {27'h0000000, enable_ff, gain_ff, just_ff, fmt_ff, res_ff};

    // address and data channels, taken in either order
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            w_hold_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (do_write) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= I_WDATA;
                wstrb_ff <= I_WSTRB;
            end
        end
    end

    // write response
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `DACFMT_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            case ({awaddr_ff[3:2], 2'b00})
                `DACFMT_ADDR_DATA: bresp_ff <= `DACFMT_RESP_OKAY;
                `DACFMT_ADDR_CTRL: bresp_ff <= `DACFMT_RESP_OKAY;
                `DACFMT_ADDR_CODE: bresp_ff <= `DACFMT_RESP_OKAY;
                default: bresp_ff <= `DACFMT_RESP_SLVERR;
            endcase
        end else if (I_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    // data word store
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            data_ff <= `DACFMT_DATA_RST; // RULE15
        end else if (do_write && ({awaddr_ff[3:2], 2'b00} == `DACFMT_ADDR_DATA)) begin
            data_ff <= nxt_data; // RULE2 RULE4 RULE5 RULE6 RULE7 RULE9 RULE11 RULE12
        end
    end

    // control bits; justification and gain are frozen while converting
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            res_ff <= 1'b0;
            fmt_ff <= 1'b0;
            just_ff <= 1'b0;
            gain_ff <= 1'b0;
            enable_ff <= 1'b0;
        end else if (do_write && wstrb_ff[0]
                     && ({awaddr_ff[3:2], 2'b00} == `DACFMT_ADDR_CTRL)) begin
            res_ff <= wdata_ff[`DACFMT_CTRL_RES]; // RULE1
            fmt_ff <= wdata_ff[`DACFMT_CTRL_FMT]; // RULE1
            enable_ff <= wdata_ff[`DACFMT_CTRL_EN];
            if (!enable_ff) begin
                just_ff <= wdata_ff[`DACFMT_CTRL_JUST]; // RULE13
                gain_ff <= wdata_ff[`DACFMT_CTRL_GAIN]; // RULE13
            end
        end
    end

    // code handed to the core, registered
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            code_ff <= `DACFMT_CODE_RST;
        end else begin
            code_ff <= core_code; // RULE14
        end
    end

    // read mux
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `DACFMT_RESP_OKAY;
        case ({I_ARADDR[3:2], 2'b00})
            `DACFMT_ADDR_DATA: nxt_rdata = {16'h0000, read_word}; // RULE3 RULE8 RULE10
            `DACFMT_ADDR_CTRL: nxt_rdata = ctrl_word;
            `DACFMT_ADDR_CODE: nxt_rdata = {20'h00000, code_ff};
            default: nxt_rresp = `DACFMT_RESP_SLVERR;
        endcase
    end

    // read channel
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `DACFMT_RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end else if (I_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule

// *** rtl/dacfmt_defines.vh ***
// How it works
// [RULE1] The data word layout is picked by three control bits: resolution (0 twelve, 1 eight), format (0 unsigned, 1 twos complement) and justification (0 right, 1 left).
// [RULE2] Twelve-bit twos complement right justified keeps the code in bits 11..0 with bit 11 as sign.
// [RULE3] In that layout bits 15..12 are read-only copies of bit 11 and follow it at once.
// [RULE4] Twelve-bit twos complement left justified keeps the code in bits 15..4 with bit 15 as sign; bits 3..0 read zero.
// [RULE5] Eight-bit unsigned right justified keeps the code in bits 7..0; bits 15..8 read zero.
// [RULE6] Eight-bit unsigned left justified keeps the code in bits 15..8; bits 7..0 read zero.
// [RULE7] Eight-bit twos complement right justified keeps the code in bits 7..0 with bit 7 as sign.
// [RULE8] In that layout bits 15..8 are read-only copies of bit 7 and follow it at once.
// [RULE9] Eight-bit twos complement left justified keeps the code in bits 15..8 with bit 15 as sign; bits 7..0 read zero.
// [RULE10] Any bit outside the field that is no sign copy ignores writes and reads zero.
// [RULE11] Twelve-bit unsigned right justified keeps the code in bits 11..0; bits 15..12 read zero.
// [RULE12] Twelve-bit unsigned left justified keeps the code in bits 15..4; bits 3..0 read zero.
// [RULE13] Software changes justification and output gain only while conversion is disabled.
// [RULE14] The core gets a right-aligned offset-binary code: left layouts shifted down, sign bit inverted.
// [RULE15] Reset clears the whole data word, so field and sign copies read zero.
`ifndef DACFMT_DEFINES_VH
`define DACFMT_DEFINES_VH

// register byte addresses
`define DACFMT_ADDR_DATA 4'h0
`define DACFMT_ADDR_CTRL 4'h4
`define DACFMT_ADDR_CODE 4'h8

// control register bit positions
`define DACFMT_CTRL_RES 0
`define DACFMT_CTRL_FMT 1
`define DACFMT_CTRL_JUST 2
`define DACFMT_CTRL_GAIN 3
`define DACFMT_CTRL_EN 4

// reset values
`define DACFMT_DATA_RST 16'h0000
`define DACFMT_CODE_RST 12'h000

// writable field masks per resolution and justification
`define DACFMT_MASK_12R 16'h0fff
`define DACFMT_MASK_12L 16'hfff0
`define DACFMT_MASK_8R 16'h00ff
`define DACFMT_MASK_8L 16'hff00

// axi responses
`define DACFMT_RESP_OKAY 2'h0
`define DACFMT_RESP_SLVERR 2'h2

`endif

// *** rtl/dacfmt_layout.v ***
`timescale 1ns/10ps
`include "dacfmt_defines.vh"

module dacfmt_layout (
    // layout select
    input wire i_res,
    input wire i_fmt,
    input wire i_just,
    // stored word
    input wire [15:0] i_word,
    // views
    output reg [15:0] o_field_mask,
    output reg [15:0] o_read_word,
    output reg [11:0] o_core_code
);

    reg [15:0] field;

    always @* begin
        field = 16'h0000;
        case ({i_res, i_just}) // RULE1
            2'b00: o_field_mask = `DACFMT_MASK_12R; // RULE2 RULE11
            2'b01: o_field_mask = `DACFMT_MASK_12L; // RULE4 RULE12
            2'b10: o_field_mask = `DACFMT_MASK_8R; // RULE5 RULE7
            2'b11: o_field_mask = `DACFMT_MASK_8L; // RULE6 RULE9
            default: o_field_mask = `DACFMT_MASK_12R;
        endcase
        field = i_word & o_field_mask; // RULE10
        o_read_word = field;
        if (i_fmt && !i_just) begin
            if (i_res) begin
                o_read_word = {{8{field[7]}}, field[7:0]}; // RULE8
            end else begin
                o_read_word = {{4{field[11]}}, field[11:0]}; // RULE3
            end
        end
        case ({i_res, i_just}) // RULE14
            2'b00: o_core_code = {field[11] ^ i_fmt, field[10:0]};
            2'b01: o_core_code = {field[15] ^ i_fmt, field[14:4]};
            2'b10: o_core_code = {4'h0, field[7] ^ i_fmt, field[6:0]};
            2'b11: o_core_code = {4'h0, field[15] ^ i_fmt, field[14:8]};
            default: o_core_code = `DACFMT_CODE_RST;
        endcase
    end

endmodule

// *** sim/dacfmt_assertions.sv ***
`timescale 1ns/10ps
module dacfmt_assertions (
    // clock and reset
    input wire I_CLK,
    input wire I_SYS_RST,
    // register bus
    input wire I_AWVALID,
    input wire O_AWREADY,
    input wire I_WVALID,
    input wire O_WREADY,
    input wire O_BVALID,
    input wire I_BREADY,
    input wire I_ARVALID,
    input wire O_ARREADY,
    input wire O_RVALID,
    input wire I_RREADY,
    input wire [31:0] O_RDATA,
    // core side
    input wire O_CORE_EIGHT_BIT,
    input wire [11:0] O_CORE_CODE
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    sequence s_wr_take; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY; endsequence
    sequence s_rd_take; I_ARVALID && O_ARREADY; endsequence
    property p_wr_ans; s_wr_take |-> ##[1:2] O_BVALID; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_rd_ans; s_rd_take |=> O_RVALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_b_stand; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
    a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
    property p_r_stand; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
    a_r_stand: assert property (p_r_stand) else $error("read answer changed");
    property p_w_refuse; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken too early");
    property p_r_refuse; O_RVALID |-> !O_ARREADY; endproperty
    a_r_refuse: assert property (p_r_refuse) else $error("read taken too early");
    property p_upper; O_RVALID |-> O_RDATA[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    // core code follows the resolution of the cycle before, so look one cycle back
    property p_core8; $past(O_CORE_EIGHT_BIT) |-> O_CORE_CODE[11:8] == 4'h0; endproperty
    a_core8: assert property (p_core8) else $error("eight-bit core code too wide");
    property p_rst; disable iff (1'b0) I_SYS_RST |=> !O_BVALID && !O_RVALID && O_CORE_CODE == 12'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    reg I_CLK = 0, I_SYS_RST = 1, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
    reg I_ARVALID = 0, I_RREADY = 0;
    reg [3:0] I_AWADDR = 0, I_WSTRB = 0, I_ARADDR = 0;
    reg [31:0] I_WDATA = 0;
    wire O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    wire O_CORE_EIGHT_BIT, O_CORE_GAIN, O_CORE_ENABLE;
    wire [1:0] O_BRESP, O_RRESP;
    wire [31:0] O_RDATA;
    wire [11:0] O_CORE_CODE;
    int n_fail = 0, checks = 0, cyc = 0;
    logic [33:0] qr[$];
    logic [1:0] qb[$];
    logic [14:0] qc[$];
    wire [14:0] core_out = {O_CORE_ENABLE, O_CORE_GAIN, O_CORE_EIGHT_BIT, O_CORE_CODE};
    logic [15:0] st = 0;
    logic [4:0] ct = 0;
    dacfmt_top i_dacfmt_top (.I_CLK, .I_SYS_RST, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA,
        .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID,
        .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .O_CORE_CODE, .O_CORE_EIGHT_BIT,
        .O_CORE_GAIN, .O_CORE_ENABLE);
    initial forever #20 I_CLK = ~I_CLK;
    function automatic logic [15:0] msk(input logic [4:0] c);
        return c[0] ? (c[2] ? 16'hff00 : 16'h00ff) : (c[2] ? 16'hfff0 : 16'h0fff);
    endfunction
    // visible word: field masked, twos right layouts sign-extended
    function automatic logic [15:0] rdv(input logic [4:0] c, input logic [15:0] s);
        logic [15:0] v;
        v = s & msk(c);
        if (c[1] && !c[2]) v = c[0] ? {{8{v[7]}}, v[7:0]} : {{4{v[11]}}, v[11:0]};
        return v;
    endfunction
    // core code: right aligned, sign bit flipped for twos
    function automatic logic [11:0] cor(input logic [4:0] c, input logic [15:0] s);
        logic [11:0] k;
        k = c[0] ? (c[2] ? {4'h0, s[15:8]} : {4'h0, s[7:0]}) : (c[2] ? s[15:4] : s[11:0]);
        if (c[1]) k = k ^ (c[0] ? 12'h080 : 12'h800);
        return k;
    endfunction
    task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t read %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t bresp %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_c(input logic [14:0] g, input logic [14:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t core %h exp %h", $time, g, e);
        end
    endtask
    always @(negedge I_CLK) begin
        if (O_RVALID && I_RREADY) cmp_r({O_RRESP, O_RDATA}, qr.pop_front());
        if (O_BVALID && I_BREADY) cmp_b(O_BRESP, qb.pop_front());
        if (qc.size() != 0) cmp_c(core_out, qc.pop_front());
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] e);
        logic ar, wd, bv;
        qb.push_back(e);
        @(posedge I_CLK);
        I_AWADDR <= a;
        I_WDATA <= d;
        I_WSTRB <= s;
        I_AWVALID <= 1;
        I_WVALID <= 1;
        I_BREADY <= 1;
        do begin
            @(negedge I_CLK);
            {ar, wd, bv} = {O_AWREADY, O_WREADY, O_BVALID};
            @(posedge I_CLK);
            if (ar) I_AWVALID <= 0;
            if (wd) I_WVALID <= 0;
        end while (!bv);
        I_BREADY <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] x, input logic [1:0] e);
        logic ar, rv;
        qr.push_back({e, 16'h0000, x});
        @(posedge I_CLK);
        I_ARADDR <= a;
        I_ARVALID <= 1;
        I_RREADY <= 1;
        do begin
            @(negedge I_CLK);
            {ar, rv} = {O_ARREADY, O_RVALID};
            @(posedge I_CLK);
            if (ar) I_ARVALID <= 0;
        end while (!rv);
        I_RREADY <= 0;
    endtask
    task automatic wd(input logic [15:0] d, input logic [3:0] s);
        logic [15:0] m;
        m = msk(ct) & {{8{s[1]}}, {8{s[0]}}};
        st = (st & ~m) | (d & m);
        wr(4'h0, {d, d}, s, 2'h0);
    endtask
    task automatic wc(input logic [4:0] c);
        if (ct[4]) c[3:2] = ct[3:2];
        ct = c;
        wr(4'h4, {27'h0, c}, 4'h1, 2'h0);
    endtask
    task conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude;
        end
    end
    initial begin
        void'($urandom(32'h0ce9));
        repeat (20) @(posedge I_CLK);
        I_SYS_RST <= 0;
        rd(4'h0, 16'h0000, 2'h0);
        rd(4'h8, 16'h0000, 2'h0);
        for (int i = 0; i < 32; i++) begin
            wc({1'b0, 1'($urandom), 3'(i)});
            wd(16'($urandom), 4'($urandom));
            rd(4'h0, rdv(ct, st), 2'h0);
            rd(4'h8, {4'h0, cor(ct, st)}, 2'h0);
            qc.push_back({ct[4], ct[3], ct[0], cor(ct, st)});
        end
        wr(4'hc, 32'($urandom), 4'hf, 2'h2);
        rd(4'hc, 16'h0000, 2'h2);
        wc(5'h10);
        wc(5'h14);
        rd(4'h4, {11'h000, ct}, 2'h0);
        wd(16'habcd, 4'h3);
        rd(4'h0, rdv(ct, st), 2'h0);
        wc(5'h00);
        wc(5'h06);
        rd(4'h0, rdv(ct, st), 2'h0);
        // reset in mid-run must clear a word that holds data
        @(posedge I_CLK);
        I_SYS_RST <= 1;
        repeat (2) @(posedge I_CLK);
        I_SYS_RST <= 0;
        st = 0;
        ct = 0;
        rd(4'h0, 16'h0000, 2'h0);
        rd(4'h4, 16'h0000, 2'h0);
        rd(4'h8, 16'h0000, 2'h0);
        qc.push_back(15'h0000);
        @(posedge I_CLK);
        conclude;
    end
endmodule
bind dacfmt_top dacfmt_assertions i_dacfmt_assertions (.I_CLK, .I_SYS_RST, .I_AWVALID, .O_AWREADY,
    .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY,
    .O_RDATA, .O_CORE_EIGHT_BIT, .O_CORE_CODE);
